// File: rtl/lcs_map.svh
// register-free constants for the label character store
`ifndef LCS_MAP_SVH
`define LCS_MAP_SVH
`define LCS_MEM_DEPTH      8192
`define LCS_LABEL_CHARS    7'd106
`define LCS_DIV_PRESET     4'h5
`define LCS_CODE_MSB       5
`define LCS_BLINK_BIT      7
`define LCS_CHAR_LSB       0
`define LCS_SEL_LSB        7
`define LCS_BANK_BIT       12
`endif

// File: rtl/lcs_pkg.sv
// types shared by the label character store
`default_nettype none
package lcs_pkg;
    typedef logic [12:0] lcs_addr_t;
    typedef logic [7:0]  lcs_byte_t;
    typedef struct packed {
        logic       blink;
        logic [5:0] code;
    } lcs_char_t;
    typedef enum logic [1:0] {
        LCS_HOST    = 2'b01,
        LCS_READOUT = 2'b10
    } lcs_path_t;
endpackage : lcs_pkg
`default_nettype wire

// File: rtl/lcs_top.sv
// label character store: 8k character memory, address multiplexer, label selector, pixel divider
// Functional notes
// - memory holds 64 labels of 106 characters in 8K bytes.
// - host 13-bit address maps straight onto memory address bits 0 to 12.
// - low write strobe enables data; byte written at strobe rising edge.
// - memory output enabled only while label line window is active.
// - byte holds code in bits 0-5, blink flag in bit 7.
// - character codes span 00 to 3F hexadecimal.
// - vertical gate low routes host address, high routes readout address.
// - vertical gate is low during scan lines 00 to 42.
// - readout address is counter 0-6, selector 7-11, bank bit 12.
// - character counter is 7 bits, only first 106 positions used.
// - 5-bit label selector captures data on label select strobe rising.
// - selector chooses a 128-byte block; counter steps through 106 characters.
// - bank bit low for full screen or upper panel, high lower panel.
// - 4-bit down divider decrements while load high, presets five when low.
// - during label lines divider reloads on each underflow, every sixth pixel.
// - counter cleared in blanking by label gate, advances once per cell.
// - read code selects 8-byte bitmap block; line count picks byte.
`include "lcs_map.svh"
`default_nettype none
module lcs_top (
    input  wire logic               sys_clk_i,
    input  wire logic               reset_n_i,
    input  wire logic               clk_en_i,
    input  wire logic               pixel_clock_a_i,
    input  wire lcs_pkg::lcs_addr_t frame_address_bus_i,
    input  wire lcs_pkg::lcs_byte_t frame_data_bus_i,
    input  wire logic               char_write_strobe_n_i,
    input  wire logic               label_select_strobe_i,
    input  wire logic               vertical_gate_i,
    input  wire logic               panel_bank_bit_i,
    input  wire logic               label_line_window_n_i,
    input  wire logic               label_gate_n_i,
    input  wire logic [2:0]         line_count_i,
    output var  lcs_pkg::lcs_char_t char_out_o,
    output var  logic               char_valid_o,
    output var  logic [8:0]         bitmap_addr_o,
    output var  logic [3:0]         pixel_div_o,
    output var  logic               div_reload_o,
    output var  logic [6:0]         char_count_o
);
    import lcs_pkg::*;

    lcs_byte_t  mem [`LCS_MEM_DEPTH];
    logic       cws_d_reg;
    logic       lss_d_reg;
    logic       pxl_d_reg;
    logic [4:0] label_sel_reg;
    logic [3:0] div_reg;
    logic [3:0] div_next;
    logic [6:0] cnt_reg;
    logic       qc_d_reg;
    lcs_path_t  path;

    logic       cws_d_reg_seen;
    wire        write_pulse = ~cws_d_reg & char_write_strobe_n_i & cws_d_reg_seen;
    wire        sel_pulse   = ~lss_d_reg & label_select_strobe_i;
    wire        pxl_rise    = ~pxl_d_reg & pixel_clock_a_i;
    wire        label_lines = ~label_line_window_n_i;
    wire        div_load    = label_lines & (div_reg != 4'h0);
    // divider bit 2 falls only on the 4 to 3 step, once per six-pixel cell
    wire        cell_edge   = qc_d_reg & ~div_reg[2];
    wire        cnt_clear   = ~label_gate_n_i;
    // vertical gate picks the memory address source
    assign path = vertical_gate_i ? LCS_READOUT : LCS_HOST;
    wire lcs_addr_t ro_addr   = {panel_bank_bit_i, label_sel_reg, cnt_reg};
    wire lcs_addr_t host_addr = frame_address_bus_i;
    wire lcs_addr_t mem_addr  = (path == LCS_READOUT) ? ro_addr : host_addr;
    wire        cnt_at_end  = (cnt_reg == `LCS_LABEL_CHARS - 7'd1);

    always_comb begin
        case (path)
            LCS_HOST:    div_next = div_reg;
            LCS_READOUT: div_next = div_reg;
            default:     div_next = div_reg;
        endcase
        if (pxl_rise) begin
            div_next = div_load ? div_reg - 4'h1 : `LCS_DIV_PRESET;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cws_d_reg      <= 1'b1;
            cws_d_reg_seen <= 1'b0;
            lss_d_reg      <= 1'b0;
            pxl_d_reg      <= 1'b0;
            qc_d_reg       <= 1'b0;
            label_sel_reg  <= 5'h00;
            div_reg        <= `LCS_DIV_PRESET;
        end else if (clk_en_i) begin
            cws_d_reg      <= char_write_strobe_n_i;
            cws_d_reg_seen <= 1'b1;
            lss_d_reg      <= label_select_strobe_i;
            pxl_d_reg      <= pixel_clock_a_i;
            qc_d_reg       <= div_reg[2];
            div_reg        <= div_next;
            if (sel_pulse) begin
                label_sel_reg <= frame_data_bus_i[4:0];
            end
        end
    end

    // character counter: cleared in blanking, one step per cell, never past 105
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= 7'h00;
        end else if (clk_en_i) begin
            if (cnt_clear) begin
                cnt_reg <= 7'h00;
            end else if (cell_edge && !cnt_at_end) begin
                cnt_reg <= cnt_reg + 7'h01;
            end
        end
    end

    // host write only on rising strobe while the host owns the memory
    always_ff @(posedge sys_clk_i) begin
        if (clk_en_i && write_pulse && path == LCS_HOST) begin
            mem[mem_addr] <= {frame_data_bus_i[`LCS_BLINK_BIT], 1'b0,
                              frame_data_bus_i[`LCS_CODE_MSB:0]};
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            char_out_o    <= '0;
            char_valid_o  <= 1'b0;
            bitmap_addr_o <= 9'h000;
            pixel_div_o   <= `LCS_DIV_PRESET;
            div_reload_o  <= 1'b0;
            char_count_o  <= 7'h00;
        end else if (clk_en_i) begin
            char_valid_o <= label_lines && path == LCS_READOUT;
            if (label_lines && path == LCS_READOUT) begin
                char_out_o    <= {mem[mem_addr][`LCS_BLINK_BIT], mem[mem_addr][5:0]};
                bitmap_addr_o <= {mem[mem_addr][5:0], line_count_i};
            end else begin
                char_out_o    <= '0;
                bitmap_addr_o <= 9'h000;
            end
            pixel_div_o  <= div_next;
            div_reload_o <= pxl_rise & label_lines & (div_reg == 4'h0);
            char_count_o <= cnt_reg;
        end
    end

    // divider checks
    AST_DIV_PRESET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && pxl_rise && !label_lines) |=> div_reg == 4'h5)
        else $error("no preset");
    AST_DIV_DEC: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && pxl_rise && div_load) |=> div_reg == $past(div_reg) - 4'h1)
        else $error("no decrement");
    AST_RELOAD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && pxl_rise && label_lines && div_reg == 4'h0) |=> (div_reg == 4'h5 && div_reload_o))
        else $error("no reload on underflow");
    AST_DIV_RANGE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        div_reg <= 4'h5)
        else $error("divider above preset");
    AST_PIXDIV: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        clk_en_i |=> pixel_div_o == div_reg)
        else $error("divider output differs");
    AST_FREEZE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !clk_en_i |=> ($stable(div_reg) && $stable(cnt_reg) && $stable(char_out_o)))
        else $error("state moved while disabled");

    // counter checks
    AST_CNT_LIMIT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        cnt_reg < 7'd106)
        else $error("counter passed label length");
    AST_CNT_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && cnt_clear) |=> cnt_reg == 7'h00)
        else $error("counter not cleared");
    AST_CNT_STEP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && cell_edge && !cnt_clear && !cnt_at_end) |=> cnt_reg == $past(cnt_reg) + 7'h01)
        else $error("counter missed a cell");
    AST_CNT_HOLD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && !cell_edge && !cnt_clear) |=> $stable(cnt_reg))
        else $error("counter moved inside a cell");
    AST_CNT_SAT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && cnt_at_end && !cnt_clear) |=> cnt_reg == 7'd105)
        else $error("counter left last position");
    AST_COUNT_OUT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        clk_en_i |=> char_count_o == $past(cnt_reg))
        else $error("count output differs");

    // selector and readout checks
    AST_SEL_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && sel_pulse) |=> label_sel_reg == $past(frame_data_bus_i[4:0]))
        else $error("sel");
    AST_SEL_HOLD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (!clk_en_i || !sel_pulse) |=> $stable(label_sel_reg))
        else $error("selector changed without strobe");
    AST_RO_ADDR: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        vertical_gate_i |-> mem_addr == {panel_bank_bit_i, label_sel_reg, cnt_reg})
        else $error("mux");
    AST_VALID_WIN: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && label_line_window_n_i) |=> !char_valid_o)
        else $error("output outside window");
    AST_VALID_ON: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && label_lines && vertical_gate_i) |=> char_valid_o)
        else $error("no output inside window");
    AST_OUT_ZERO: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (clk_en_i && !label_lines) |=> (char_out_o == '0 && bitmap_addr_o == 9'h000))
        else $error("data outside window");
    AST_BITMAP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ($past(clk_en_i) && char_valid_o) |-> bitmap_addr_o[2:0] == $past(line_count_i))
        else $error("bitmap line");
    AST_BITMAP_CODE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        char_valid_o |-> bitmap_addr_o[8:3] == char_out_o.code)
        else $error("bitmap block");

    // coverage of the main scenarios
    COV_WRITE: cover property (@(posedge sys_clk_i) clk_en_i && write_pulse && !vertical_gate_i);
    COV_RELOAD: cover property (@(posedge sys_clk_i) div_reload_o);
    COV_STEP: cover property (@(posedge sys_clk_i) clk_en_i && cell_edge && !cnt_clear);
    COV_SATURATE: cover property (@(posedge sys_clk_i) clk_en_i && cell_edge && cnt_at_end && !cnt_clear);
    COV_DROP: cover property (@(posedge sys_clk_i) clk_en_i && write_pulse && vertical_gate_i);
endmodule : lcs_top
`default_nettype wire

// File: verification/lcs_host_model.sv
// host-side writer of label characters and label selections
`default_nettype none
module lcs_host_model (
    input  wire logic               clk_i,
    output var  lcs_pkg::lcs_addr_t addr_o = '0,
    output var  lcs_pkg::lcs_byte_t data_o = '0,
    output var  logic               wr_n_o = 1'b1,
    output var  logic               sel_o  = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic put_char(input lcs_pkg::lcs_addr_t a, input lcs_pkg::lcs_byte_t d);
        @(negedge clk_i);
        addr_o <= a;
        data_o <= d;
        wr_n_o <= 1'b0;
        @(negedge clk_i);
        wr_n_o <= 1'b1;
        @(negedge clk_i);
        addr_o <= ~a;
        data_o <= ~d;
    endtask : put_char
    task automatic put_sel(input lcs_pkg::lcs_byte_t d);
        @(negedge clk_i);
        data_o <= d;
        sel_o  <= 1'b1;
        @(negedge clk_i);
        sel_o  <= 1'b0;
        data_o <= ~d;
    endtask : put_sel
endmodule : lcs_host_model
`default_nettype wire

// File: verification/lcs_top_tb.sv
// self-checking bench for the label character store
`default_nettype none
module lcs_top_tb;
    import lcs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk_i = 0, reset_n_i = 0, pix = 0, vg = 0, bank = 0, win_n = 1, gate_n = 0, chk = 0, ce = 1;
    logic [2:0] line = 3'h0, line_q = 3'h0;
    lcs_addr_t  addr;
    lcs_byte_t  data, d;
    logic       wr_n, sel, valid, reload;
    lcs_char_t  char_out;
    logic [3:0] div;
    logic [6:0] cnt;
    logic [8:0] bmap;
    int         error_cnt = 0, check_count = 0, reloads = 0, mem[int];
    integer     seed = 32'h47bf48df;
    lcs_host_model HOST (.clk_i(sys_clk_i), .addr_o(addr), .data_o(data), .wr_n_o(wr_n), .sel_o(sel));
    lcs_top DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(ce), .pixel_clock_a_i(pix),
        .frame_address_bus_i(addr), .frame_data_bus_i(data), .char_write_strobe_n_i(wr_n),
        .label_select_strobe_i(sel), .vertical_gate_i(vg), .panel_bank_bit_i(bank),
        .label_line_window_n_i(win_n), .label_gate_n_i(gate_n), .line_count_i(line),
        .char_out_o(char_out), .char_valid_o(valid), .bitmap_addr_o(bmap), .pixel_div_o(div),
        .div_reload_o(reload), .char_count_o(cnt));
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    task automatic pix_rises(input int n);
        repeat (n) begin
            @(negedge sys_clk_i);
            pix = 1'b1;
            line = 3'($random(seed));
            repeat (2) @(negedge sys_clk_i);
            pix = 1'b0;
            // a random frozen cycle while the pixel level is steady
            ce = 1'($random(seed));
            @(negedge sys_clk_i);
            ce = 1'b1;
            @(negedge sys_clk_i);
        end
    endtask : pix_rises
    // pre-edge values only, so design updates never race the sampling
    always @(posedge sys_clk_i) begin
        if (chk && valid === 1'b1) begin
            check(8'(char_out), 8'(mem[{bank, 5'h05, cnt}]));
            check(8'(bmap[8:3]), 8'(mem[{bank, 5'h05, cnt}] & 'h3F));
            check(8'(bmap[2:0]), 8'(line_q));
            check(8'(cnt > 7'h69), 8'h00);
        end
        if (chk) begin
            reloads += reload;
        end
        line_q <= line;
    end
    initial begin
        #1ms;
        error_cnt++;
        wrap_up();
    end
    initial begin
        repeat (16) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 128; i++) begin
                d = 8'($random(seed));
                mem[{b[0], 5'd5, 7'(i)}] = {d[7], d[5:0]};
                HOST.put_char({b[0], 5'd5, 7'(i)}, d);
            end
        end
        HOST.put_sel(8'h05);
        vg = 1'b1;
        // this write must be dropped while readout owns the memory
        HOST.put_char(13'h0280, 8'h3F);
        pix_rises(3);
        check(8'(div), 8'h05);
        for (int b = 0; b < 2; b++) begin
            bank = b[0];
            win_n = 1'b0;
            gate_n = 1'b1;
            chk = 1'b1;
            reloads = 0;
            pix_rises(660);
            repeat (3) @(negedge sys_clk_i);
            chk = 1'b0;
            check(8'(reloads), 8'h6E);
            check(8'(cnt), 8'h69);
            win_n = 1'b1;
            gate_n = 1'b0;
            repeat (3) @(negedge sys_clk_i);
            check(8'(cnt), 8'h00);
        end
        wrap_up();
    end
endmodule : lcs_top_tb
`default_nettype wire
